// file: design/dio_port.sv
// byte-wide general io port with display mode, per-line interrupts on 17 lines and debounce
//
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "dio_regs.svh"

// Functional notes
// - twenty lines: eleven display, nine general
// - display lines: plain io or display interface
// - every line direction set independently
// - each line has data and direction bit
// - direction one is output, zero input
// - eight-bit registers on word addresses
// - upper 24 bits ignored, read zero
// - data write drives output lines only
// - data read returns actual pin level
// - interrupt settings independent per line; display lines 8-10 have no interrupt
// - high, low, rising or falling trigger
// - debounce selectable per line interrupt
// - debounce: two-stage shift at 128 Hz
// - dedicated bit 2 low powers phy down
module dio_port
   import dio_pkg::*;
#(
   parameter int DEB_DIV = `DIO_DEB_CYC
) (
   // clock, reset, enable
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic        ce,
   // register port
   input  wire logic [7:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [31:0] rdata,
   // general header lines
   input  wire logic [8:0]  gen_in,
   output logic      [8:0]  gen_out,
   output logic      [8:0]  gen_oe,
   // display header lines
   input  wire logic [10:0] disp_in,
   output logic      [10:0] disp_out,
   output logic      [10:0] disp_oe,
   // dedicated port and interrupt
   output logic      [7:0]  ded_out,
   output logic             phy_pwr_on,
   output logic             irq
);

   localparam logic [21:0] DEB_LAST = 22'(DEB_DIV - 1);
   localparam logic [5:0]  EN_LAST  = 6'(`DIO_EN_CYC - 1);

   // interrupt bank of an address, 3 when not an interrupt register
   function automatic logic [1:0] irq_bank(input logic [7:0] a);
      logic [7:0] off;
      off = a - `DIO_A_IRQ;
      if (a < `DIO_A_IRQ || off >= 8'(3 * `DIO_IRQ_STR)) begin
         irq_bank = 2'd3;
      end else begin
         irq_bank = off[6:5];
      end
   endfunction

   // bus request bundle
   dio_req_t req;
   assign req = '{addr: addr, wdata: wdata[7:0], wr: wr, rd: rd};

   // ---------------- pin synchronisers ----------------
   logic [19:0] s1_reg, s2_reg, s3_reg, lvl_reg;   // three stages and level
   logic [19:0] s1_next, s2_next, s3_next, lvl_next;

   // level follows once stages two and three agree
   always_comb begin
      s1_next  = {disp_in, gen_in};
      s2_next  = s1_reg;
      s3_next  = s2_reg;
      lvl_next = (~(s2_reg ^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & lvl_reg);
   end

   // sync registers, reset to the pulled-up level
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s1_reg  <= `DIO_PIN_RST;
         s2_reg  <= `DIO_PIN_RST;
         s3_reg  <= `DIO_PIN_RST;
         lvl_reg <= `DIO_PIN_RST;
      end else if (ce) begin
         s1_reg  <= s1_next;
         s2_reg  <= s2_next;
         s3_reg  <= s3_next;
         lvl_reg <= lvl_next;
      end
   end

   // interrupt-capable lines: general 0-7, display 0-7, general 8
   logic [23:0] iv;
   assign iv = {7'h00, lvl_reg[8], lvl_reg[16:9], lvl_reg[7:0]};

   // ---------------- software registers ----------------
   logic [8:0]   gdat_reg, gdat_next;    // general output latch
   logic [8:0]   gdir_reg, gdir_next;    // general direction
   logic [10:0]  ddat_reg, ddat_next;    // display output latch
   logic [10:0]  ddir_reg, ddir_next;    // display direction
   logic         dmode_reg, dmode_next;  // display interface on
   logic [7:0]   ded_reg, ded_next;      // dedicated port
   dio_irq_cfg_t cfg_reg, cfg_next;      // interrupt settings
   logic [23:0]  clr_wr;                 // clear strobes
   logic [31:0]  rdata_reg, rdata_next;  // read answer
   logic         go_req;                 // start display transfer
   logic         go_rs;                  // register select for it
   logic [23:0]  stat_reg;               // sticky interrupt status
   logic         busy;                   // display transfer running
   logic [1:0]   bank;                   // decoded interrupt bank
   logic [2:0]   rsel;                   // decoded bank register

   assign bank = irq_bank(req.addr);
   assign rsel = req.addr[4:2];  // word-aligned byte-wide registers

   // write decode and read mux
   always_comb begin
      gdat_next  = gdat_reg;
      gdir_next  = gdir_reg;
      ddat_next  = ddat_reg;
      ddir_next  = ddir_reg;
      dmode_next = dmode_reg;
      ded_next   = ded_reg;
      cfg_next   = cfg_reg;
      clr_wr     = 24'h000000;
      go_req     = 1'b0;
      go_rs      = 1'b0;
      rdata_next = 32'h00000000;  // unmapped and upper bits read zero
      if (req.wr) begin
         case (req.addr)
            // latches hold any value; only output lines drive it
            `DIO_A_GDAT:  gdat_next[7:0] = req.wdata;
            `DIO_A_GDIR:  gdir_next[7:0] = req.wdata;
            `DIO_A_GHDAT: gdat_next[8] = req.wdata[0];
            `DIO_A_GHDIR: gdir_next[8] = req.wdata[0];
            `DIO_A_DDAT:  ddat_next[7:0] = req.wdata;
            `DIO_A_DDIR:  ddir_next[7:0] = req.wdata;
            `DIO_A_DCDAT: ddat_next[10:8] = req.wdata[2:0];
            `DIO_A_DCDIR: ddir_next[10:8] = req.wdata[2:0];
            `DIO_A_DMODE: dmode_next = req.wdata[`DIO_MODE_DISP];
            `DIO_A_DCMD: begin
               go_req = 1'b1;
               go_rs  = 1'b0;
            end
            `DIO_A_DCHR: begin
               go_req = 1'b1;
               go_rs  = 1'b1;
            end
            `DIO_A_DED:   ded_next = req.wdata;
            default: begin
               // per-line interrupt settings
               if (bank != 2'd3) begin
                  case (rsel)
                     `DIO_R_EN:   cfg_next.en[bank*8 +: 8]       = req.wdata;
                     `DIO_R_EDGE: cfg_next.edge_sel[bank*8 +: 8] = req.wdata;
                     `DIO_R_POL:  cfg_next.pol[bank*8 +: 8]      = req.wdata;
                     `DIO_R_DEB:  cfg_next.deb[bank*8 +: 8]      = req.wdata;
                     `DIO_R_CLR:  clr_wr[bank*8 +: 8]            = req.wdata;
                     default:     clr_wr = 24'h000000;
                  endcase
               end
            end
         endcase
      end
      if (req.rd) begin
         case (req.addr)
            // data reads show the pin, not the latch
            `DIO_A_GDAT:  rdata_next[7:0] = lvl_reg[7:0];
            `DIO_A_GDIR:  rdata_next[7:0] = gdir_reg[7:0];
            `DIO_A_GHDAT: rdata_next[0] = lvl_reg[8];
            `DIO_A_GHDIR: rdata_next[0] = gdir_reg[8];
            `DIO_A_DDAT:  rdata_next[7:0] = lvl_reg[16:9];
            `DIO_A_DDIR:  rdata_next[7:0] = ddir_reg[7:0];
            `DIO_A_DCDAT: rdata_next[2:0] = lvl_reg[19:17];
            `DIO_A_DCDIR: rdata_next[2:0] = ddir_reg[10:8];
            `DIO_A_DMODE: begin
               rdata_next[`DIO_MODE_DISP] = dmode_reg;
               rdata_next[`DIO_MODE_BUSY] = busy;
            end
            `DIO_A_DED:   rdata_next[7:0] = ded_reg;
            default: begin
               if (bank != 2'd3) begin
                  case (rsel)
                     `DIO_R_EN:   rdata_next[7:0] = cfg_reg.en[bank*8 +: 8];
                     `DIO_R_EDGE: rdata_next[7:0] = cfg_reg.edge_sel[bank*8 +: 8];
                     `DIO_R_POL:  rdata_next[7:0] = cfg_reg.pol[bank*8 +: 8];
                     `DIO_R_DEB:  rdata_next[7:0] = cfg_reg.deb[bank*8 +: 8];
                     `DIO_R_STAT: rdata_next[7:0] = stat_reg[bank*8 +: 8];
                     default:     rdata_next = 32'h00000000;
                  endcase
               end
            end
         endcase
      end
   end

   // software register storage
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         gdat_reg  <= 9'h000;
         gdir_reg  <= 9'h000;
         ddat_reg  <= 11'h000;
         ddir_reg  <= 11'h000;
         dmode_reg <= 1'b0;
         ded_reg   <= `DIO_DED_RST;
         cfg_reg   <= '0;
         rdata_reg <= 32'h00000000;
      end else if (ce) begin
         gdat_reg  <= gdat_next;
         gdir_reg  <= gdir_next;
         ddat_reg  <= ddat_next;
         ddir_reg  <= ddir_next;
         dmode_reg <= dmode_next;
         ded_reg   <= ded_next;
         cfg_reg   <= cfg_next;
         rdata_reg <= rdata_next;
      end
   end

   // ---------------- debounce and interrupt detect ----------------
   logic [21:0] div_reg, div_next;    // 128 Hz divider
   logic        tick;                 // one debounce sample
   logic [23:0] sh0_reg, sh0_next;    // first debounce stage
   logic [23:0] sh1_reg, sh1_next;    // second debounce stage
   logic [23:0] dlvl_reg, dlvl_next;  // debounced level
   logic [23:0] prev_reg, prev_next;  // last selected level
   logic [23:0] stat_next;            // status next value
   logic [23:0] src;                  // level seen by detectors
   logic [23:0] ev;                   // detected events

   assign tick = (div_reg == DEB_LAST);

   // sample shift, agreement and trigger selection
   always_comb begin
      div_next  = tick ? 22'h000000 : div_reg + 22'h000001;
      sh0_next  = sh0_reg;
      sh1_next  = sh1_reg;
      dlvl_next = dlvl_reg;
      if (tick) begin
         sh0_next = iv;
         sh1_next = sh0_reg;
      end
      // level accepted only when both stages agree
      dlvl_next = (~(sh0_reg ^ sh1_reg) & sh1_reg) | ((sh0_reg ^ sh1_reg) & dlvl_reg);
      src       = (cfg_reg.deb & dlvl_reg) | (~cfg_reg.deb & iv);
      prev_next = src;
      // edge or level, polarity picks high/rising
      ev = (cfg_reg.edge_sel & cfg_reg.pol & src & ~prev_reg)
         | (cfg_reg.edge_sel & ~cfg_reg.pol & ~src & prev_reg)
         | (~cfg_reg.edge_sel & cfg_reg.pol & src)
         | (~cfg_reg.edge_sel & ~cfg_reg.pol & ~src);
      // set wins over a clear in the same cycle
      stat_next = ((stat_reg & ~clr_wr) | ev) & `DIO_IRQ_VALID;
   end

   // debounce and status storage
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         div_reg  <= 22'h000000;
         sh0_reg  <= 24'hffffff;
         sh1_reg  <= 24'hffffff;
         dlvl_reg <= 24'hffffff;
         prev_reg <= 24'hffffff;
         stat_reg <= 24'h000000;
      end else if (ce) begin
         div_reg  <= div_next;
         sh0_reg  <= sh0_next;
         sh1_reg  <= sh1_next;
         dlvl_reg <= dlvl_next;
         prev_reg <= prev_next;
         stat_reg <= stat_next;
      end
   end

   // ---------------- display interface sequencer ----------------
   dio_disp_st_t st_reg, st_next;    // transfer state
   logic [5:0]   cnt_reg, cnt_next;  // phase timer
   logic [7:0]   byte_reg, byte_next;
   logic         rs_reg, rs_next;

   assign busy = (st_reg != DIO_IDLE);

   // setup, enable pulse and hold, each one phase long
   always_comb begin
      st_next   = st_reg;
      cnt_next  = cnt_reg;
      byte_next = byte_reg;
      rs_next   = rs_reg;
      case (st_reg)
         DIO_IDLE: begin
            // writes while off or busy are dropped
            if (go_req && dmode_reg) begin
               st_next   = DIO_SETUP;
               cnt_next  = 6'h00;
               byte_next = req.wdata;
               rs_next   = go_rs;
            end
         end
         DIO_SETUP, DIO_PULSE, DIO_HOLD: begin
            if (cnt_reg == EN_LAST) begin
               cnt_next = 6'h00;
               case (st_reg)
                  DIO_SETUP: st_next = DIO_PULSE;
                  DIO_PULSE: st_next = DIO_HOLD;
                  default:   st_next = DIO_IDLE;
               endcase
            end else begin
               cnt_next = cnt_reg + 6'h01;
            end
         end
         default: st_next = DIO_IDLE;
      endcase
   end

   // sequencer storage
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_reg   <= DIO_IDLE;
         cnt_reg  <= 6'h00;
         byte_reg <= 8'h00;
         rs_reg   <= 1'b0;
      end else if (ce) begin
         st_reg   <= st_next;
         cnt_reg  <= cnt_next;
         byte_reg <= byte_next;
         rs_reg   <= rs_next;
      end
   end

   // ---------------- outputs ----------------
   // 20 lines: nine general, eleven display
   assign gen_out  = gdat_reg;
   assign gen_oe   = gdir_reg;  // one drives, zero floats
   // display mode drives all lines: byte, rs, rw low, enable
   assign disp_out = dmode_reg ? {(st_reg == DIO_PULSE), 1'b0, rs_reg, byte_reg} : ddat_reg;
   assign disp_oe  = dmode_reg ? 11'h7ff : ddir_reg;
   assign ded_out  = ded_reg;
   assign phy_pwr_on = ded_reg[`DIO_PHY_BIT];  // zero powers phy down
   assign irq   = |(stat_reg & cfg_reg.en);
   assign rdata = rdata_reg;

endmodule
`default_nettype wire

// file: pkg/dio_regs.svh
// register offsets, field positions, reset values and timing counts of the digital io port
`ifndef DIO_REGS_SVH
`define DIO_REGS_SVH

// byte offsets of the port registers
`define DIO_A_GDAT   8'h00
`define DIO_A_GDIR   8'h04
`define DIO_A_GHDAT  8'h08
`define DIO_A_GHDIR  8'h0c
`define DIO_A_DDAT   8'h10
`define DIO_A_DDIR   8'h14
`define DIO_A_DCDAT  8'h18
`define DIO_A_DCDIR  8'h1c
`define DIO_A_DMODE  8'h20
`define DIO_A_DCMD   8'h24
`define DIO_A_DCHR   8'h28
`define DIO_A_DED    8'h2c
// interrupt banks: base + bank * stride + reg * 4
`define DIO_A_IRQ    8'h40
`define DIO_IRQ_STR  8'h20
`define DIO_R_EN     3'd0
`define DIO_R_EDGE   3'd1
`define DIO_R_POL    3'd2
`define DIO_R_DEB    3'd3
`define DIO_R_STAT   3'd4
`define DIO_R_CLR    3'd5

// field positions
`define DIO_MODE_DISP  0
`define DIO_MODE_BUSY  1
`define DIO_PHY_BIT    2

// reset values
`define DIO_DED_RST    8'h04
`define DIO_PIN_RST    20'hfffff
`define DIO_IRQ_VALID  24'h01ffff

// timing
`define DIO_CLK_MHZ    125
`define DIO_EN_NS      500
`define DIO_EN_CYC     ((`DIO_EN_NS * `DIO_CLK_MHZ + 999) / 1000)
`define DIO_DEB_NS     7812500
`define DIO_DEB_CYC    ((`DIO_DEB_NS * `DIO_CLK_MHZ) / 1000)

`endif

// file: pkg/dio_pkg.sv
// types shared by the digital io port
package dio_pkg;
   // display transfer sequencer states
   typedef enum logic [3:0] {
      DIO_IDLE  = 4'b0001,
      DIO_SETUP = 4'b0010,
      DIO_PULSE = 4'b0100,
      DIO_HOLD  = 4'b1000
   } dio_disp_st_t;

   // one register bus request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } dio_req_t;

   // per-line interrupt configuration, all banks side by side
   typedef struct packed {
      logic [23:0] en;
      logic [23:0] edge_sel;
      logic [23:0] pol;
      logic [23:0] deb;
   } dio_irq_cfg_t;
endpackage

// file: tb/dio_port_checker.sv
// assertion checker for the digital io port
`timescale 1ns/100ps
`default_nettype none
`include "dio_regs.svh"
module dio_port_checker
   import dio_pkg::*;
#(
   parameter int DEB_DIV = 8
) (
   // clock, reset and enable
   input wire logic        clk,
   input wire logic        arst_n,
   input wire logic        ce,
   // register port
   input wire logic [7:0]  addr,
   input wire logic [31:0] wdata,
   input wire logic        wr,
   input wire logic        rd,
   input wire logic [31:0] rdata,
   // pins and outputs
   input wire logic [8:0]  gen_in,
   input wire logic [8:0]  gen_out,
   input wire logic [8:0]  gen_oe,
   input wire logic [10:0] disp_in,
   input wire logic [10:0] disp_out,
   input wire logic [10:0] disp_oe,
   input wire logic [7:0]  ded_out,
   input wire logic        phy_pwr_on,
   input wire logic        irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   // upper read bits always zero
   a_rdata_upper_zero: assert property (rdata[31:8] == 24'h000000)
      else $error("rdata upper bits not zero");
   // read data only after a read strobe
   a_rdata_idle_zero: assert property ($past(ce) && !$past(rd) |-> rdata == 32'h00000000)
      else $error("rdata not zero without read");
   // direction write reaches the enables
   a_dir_write_oe: assert property (ce && wr && addr == `DIO_A_GDIR |=> gen_oe[7:0] == $past(wdata[7:0]))
      else $error("gen_oe does not follow direction write");
   // line eight has its own direction bit
   a_line8_dir: assert property (ce && wr && addr == `DIO_A_GHDIR |=> gen_oe[8] == $past(wdata[0]))
      else $error("line eight direction wrong");
   // data write reaches the output latch
   a_data_latch: assert property (ce && wr && addr == `DIO_A_GDAT |=> gen_out[7:0] == $past(wdata[7:0]))
      else $error("gen_out does not follow data write");
   // enables hold without a direction write
   a_oe_hold: assert property (!(wr && addr == `DIO_A_GDIR) |=> $stable(gen_oe[7:0]))
      else $error("gen_oe changed without write");
   // phy power follows bit 2
   a_phy_follow: assert property (phy_pwr_on == ded_out[`DIO_PHY_BIT])
      else $error("phy power not bit 2");
   // dedicated port keeps the low byte only
   a_ded_write: assert property (ce && wr && addr == `DIO_A_DED |=> ded_out == $past(wdata[7:0]))
      else $error("dedicated port write wrong");
   // display mode takes every display line as output
   a_disp_mode_oe: assert property (ce && wr && addr == `DIO_A_DMODE && wdata[0] |=> disp_oe == 11'h7ff)
      else $error("display mode does not drive all lines");
endmodule
bind dio_port dio_port_checker #(.DEB_DIV(DEB_DIV)) chk_u (.clk(clk), .arst_n(arst_n), .ce(ce),
   .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .gen_in(gen_in), .gen_out(gen_out),
   .gen_oe(gen_oe), .disp_in(disp_in), .disp_out(disp_out), .disp_oe(disp_oe), .ded_out(ded_out),
   .phy_pwr_on(phy_pwr_on), .irq(irq));
`default_nettype wire

// file: tb/dio_pins_model.sv
// model of the devices and pull-ups on the header pins
`timescale 1ns/100ps
`default_nettype none
module dio_pins_model (
   // port side
   input  wire logic [8:0]  gen_out,
   input  wire logic [8:0]  gen_oe,
   input  wire logic [10:0] disp_out,
   input  wire logic [10:0] disp_oe,
   // external device drive, lines 0-7
   input  wire logic [7:0]  ext_oe,
   input  wire logic [7:0]  ext_val,
   // resolved pin levels
   output logic      [8:0]  gen_in,
   output logic      [10:0] disp_in
);
   // port drive wins, then device, else pull-up to one
   always_comb begin
      gen_in  = (gen_oe & gen_out) | (~gen_oe & {1'b0, ext_oe & ext_val}) | (~gen_oe & ~{1'b0, ext_oe});
      disp_in = (disp_oe & disp_out) | ~disp_oe;
   end
endmodule
`default_nettype wire

// file: tb/dio_port_tb.sv
// self-checking bench of the digital io port
`timescale 1ns/100ps
`default_nettype none
`include "dio_regs.svh"
module dio_port_tb;
   typedef struct packed {
      logic [7:0]  a;
      logic [31:0] d;
      logic [31:0] e;
   } dio_row_t;
   logic        clk, arst_n, ce, wr, rd, irq, phy_pwr_on;
   logic [7:0]  addr, ded_out, ext_oe, ext_val;
   logic [31:0] wdata, rdata, v;
   logic [8:0]  gen_in, gen_out, gen_oe;
   logic [10:0] disp_in, disp_out, disp_oe;
   int          bad_count, compares;
   // write, read-back rows
   dio_row_t rows [8] = '{
      '{`DIO_A_GDIR, 32'hffffffa5, 32'h000000a5},
      '{`DIO_A_GHDIR, 32'h000000ff, 32'h00000001},
      '{`DIO_A_DDIR, 32'h0000003c, 32'h0000003c},
      '{`DIO_A_DED, 32'hffffff5b, 32'h0000005b},
      '{8'h40, 32'h00000011, 32'h00000011},
      '{8'h44, 32'h000000c3, 32'h000000c3},
      '{8'h4c, 32'h00000081, 32'h00000081},
      '{8'h3c, 32'h000000ff, 32'h00000000}};

   dio_port #(.DEB_DIV(8)) dut_u (.clk(clk), .arst_n(arst_n), .ce(ce), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .gen_in(gen_in), .gen_out(gen_out), .gen_oe(gen_oe),
      .disp_in(disp_in), .disp_out(disp_out), .disp_oe(disp_oe), .ded_out(ded_out),
      .phy_pwr_on(phy_pwr_on), .irq(irq));
   dio_pins_model pins_u (.gen_out(gen_out), .gen_oe(gen_oe), .disp_out(disp_out), .disp_oe(disp_oe),
      .ext_oe(ext_oe), .ext_val(ext_val), .gen_in(gen_in), .disp_in(disp_in));

   // 125 MHz clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // one-cycle write strobe
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask
   // one-cycle read, data sampled the cycle after
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1 d = rdata;
   endtask
   // compare and count
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk);
   endtask
   // verdict
   task automatic close_out;
      if (bad_count == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // watchdog
   initial begin
      step(6000);
      bad_count++;
      close_out;
   end
   // main sequence
   initial begin
      arst_n = 1'b0; ce = 1'b1; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 32'h0;
      ext_oe = 8'h00; ext_val = 8'hff; bad_count = 0; compares = 0;
      step(16);
      arst_n <= 1'b1;
      rd_reg(`DIO_A_DED, v); check(v, 32'h00000004);
      check({31'h0, phy_pwr_on}, 32'h1);
      foreach (rows[i]) begin
         wr_reg(rows[i].a, rows[i].d);
         rd_reg(rows[i].a, v); check(v, rows[i].e);
      end
      check({31'h0, phy_pwr_on}, 32'h0);
      // mixed directions: read shows pins, write only drives outputs
      ext_oe <= 8'hff; ext_val <= 8'h3c;
      wr_reg(`DIO_A_GDIR, 32'h0f);
      wr_reg(`DIO_A_GDAT, 32'hff);
      step(6);
      rd_reg(`DIO_A_GDAT, v); check(v, 32'h3f);
      // read-modify-write of one line
      wr_reg(`DIO_A_GDAT, v & 32'hfe);
      step(6);
      rd_reg(`DIO_A_GDAT, v); check(v, 32'h3e);
      wr_reg(`DIO_A_GDIR, 32'h00);
      // bits 4..7 high, low, rising, falling; bit 3 rising debounced; bits 0..2 high, idle low
      wr_reg(8'h40, 32'h00);
      wr_reg(8'h44, 32'hc8);
      wr_reg(8'h48, 32'h5f);
      wr_reg(8'h4c, 32'h08);
      ext_val <= 8'h00;
      step(40);
      wr_reg(8'h54, 32'hff);
      rd_reg(8'h50, v); check(v, 32'h20);
      ext_val <= 8'hf0;
      step(10);
      rd_reg(8'h50, v); check(v, 32'h70);
      ext_val <= 8'h00;
      step(10);
      rd_reg(8'h50, v); check(v, 32'hf0);
      check({31'h0, irq}, 32'h0);
      wr_reg(8'h40, 32'h80);
      step(1);
      check({31'h0, irq}, 32'h1);
      wr_reg(8'h54, 32'hff);
      rd_reg(8'h50, v); check(v, 32'h20);
      check({31'h0, irq}, 32'h0);
      // short glitch is filtered, stable level accepted
      ext_val <= 8'h08;
      step(2);
      ext_val <= 8'h00;
      step(40);
      rd_reg(8'h50, v); check(v, 32'h20);
      ext_val <= 8'h08;
      step(40);
      rd_reg(8'h50, v); check(v, 32'h28);
      // display interface: one character transfer, command while busy dropped
      wr_reg(`DIO_A_DMODE, 32'h01);
      step(1);
      check({21'h0, disp_oe}, 32'h7ff);
      wr_reg(`DIO_A_DCHR, 32'h41);
      rd_reg(`DIO_A_DMODE, v); check(v, 32'h03);
      check({21'h0, disp_out}, 32'h141);
      wr_reg(`DIO_A_DCMD, 32'h99);
      step(70);
      check({21'h0, disp_out}, 32'h541);
      step(130);
      rd_reg(`DIO_A_DMODE, v); check(v, 32'h01);
      check({21'h0, disp_out}, 32'h141);
      wr_reg(`DIO_A_DMODE, 32'h00);
      step(1);
      check({21'h0, disp_oe}, 32'h03c);
      // reset in mid-run returns the registers to their reset values
      arst_n <= 1'b0;
      step(2);
      check({24'h0, ded_out}, 32'h04);
      check({23'h0, gen_oe}, 32'h0);
      check({31'h0, irq}, 32'h0);
      arst_n <= 1'b1;
      rd_reg(`DIO_A_DED, v); check(v, 32'h04);
      // clock enable low: the write is not taken
      ce <= 1'b0;
      wr_reg(`DIO_A_DED, 32'h00);
      ce <= 1'b1;
      check({31'h0, phy_pwr_on}, 32'h1);
      rd_reg(`DIO_A_DED, v); check(v, 32'h04);
      close_out;
   end
endmodule
`default_nettype wire
